// File: core/fskm_core.sv
// What this block does
// - Standard input picks US or international plan.
// - Transmit bit high is sent as mark.
// - Tones are synthesised sines from 1 MHz reference.
// - No tone leaves unless transmit enable is high.
// - Mode picks originate/channel 1 or answer/channel 2.
// - Echo request in channel 2 mark sends 2100 Hz.
// - Recovered bit comes from demodulated receive carrier.
// - Bit changes after new tone holds half period.
// - Rate and standard pick 200, 300 or 600 bps.
// - Loopback check feeds demodulator the modulator's own tone.
// - Demodulator reset high disables the demodulator.
// - Pull-ups on unless pull-up disable is high.
`include "fskm_defs.svh"
module fskm_core
  import fskm_pkg::*;
#(
  parameter int F_US_ORIG_SPACE = 1070,
  parameter int F_CC1_MARK      = 980,
  parameter int F_CC2_MARK      = 1650,
  parameter int REF_DIV         = `FSKM_REF_DIV
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        tx_bit_i,
  input  wire logic        rx_carrier_i,
  output logic      [7:0]  tone_o,
  output logic             tone_active_o,
  output logic             rx_bit_o,
  output logic             rx_valid_o,
  output logic             rx_data_o,
  input  wire logic        rx_ready_i,
  output logic             pullup_en_o
);
  function automatic fskm_inc_t inc_of(input int f);
    inc_of = 24'((64'(f) * `FSKM_ACC_ONE) / 64'(`FSKM_REF_HZ));
  endfunction

  function automatic fskm_per_t mid_per(input int fa, input int fb);
    mid_per = 13'((`FSKM_REF_HZ / fa + `FSKM_REF_HZ / fb) / 2);
  endfunction

  localparam fskm_inc_t INC_UOM  = inc_of(`FSKM_F_US_OM);
  localparam fskm_inc_t INC_UOS  = inc_of(F_US_ORIG_SPACE);
  localparam fskm_inc_t INC_UAM  = inc_of(`FSKM_F_US_AM);
  localparam fskm_inc_t INC_UAS  = inc_of(`FSKM_F_US_AS);
  localparam fskm_inc_t INC_C1M  = inc_of(F_CC1_MARK);
  localparam fskm_inc_t INC_C1S  = inc_of(`FSKM_F_CC1_S);
  localparam fskm_inc_t INC_C2M  = inc_of(F_CC2_MARK);
  localparam fskm_inc_t INC_C2S  = inc_of(`FSKM_F_CC2_S);
  localparam fskm_inc_t INC_ECHO = inc_of(`FSKM_F_ECHO);
  localparam fskm_per_t TH_UO = mid_per(`FSKM_F_US_OM, F_US_ORIG_SPACE);
  localparam fskm_per_t TH_UA = mid_per(`FSKM_F_US_AM, `FSKM_F_US_AS);
  localparam fskm_per_t TH_C1 = mid_per(F_CC1_MARK, `FSKM_F_CC1_S);
  localparam fskm_per_t TH_C2 = mid_per(F_CC2_MARK, `FSKM_F_CC2_S);
  localparam fskm_per_t HB_200 = 13'(`FSKM_HALF_200);
  localparam fskm_per_t HB_300 = 13'(`FSKM_HALF_300);
  localparam fskm_per_t HB_600 = 13'(`FSKM_HALF_600);
  localparam logic [7:0] REF_LAST = 8'(REF_DIV - 1);

  // Transmit frequency table; the echo tone overrides channel 2 mark.
  function automatic fskm_inc_t tx_inc(input logic std, input logic mode,
                                       input logic mark, input logic echo);
    if (echo && !std && !mode && mark) begin
      tx_inc = INC_ECHO;
    end else if (std) begin
      tx_inc = mode ? (mark ? INC_UOM : INC_UOS)
                    : (mark ? INC_UAM : INC_UAS);
    end else begin
      tx_inc = mode ? (mark ? INC_C1M : INC_C1S)
                    : (mark ? INC_C2M : INC_C2S);
    end
  endfunction

  // Rate bit set gives 300 bps with the US plan and 200 bps with the international plan; clear gives 600 bps.
  function automatic fskm_per_t half_of(input logic rate, input logic std);
    if (rate) begin
      half_of = std ? HB_300 : HB_200;
    end else begin
      half_of = HB_600;
    end
  endfunction

  fskm_link_if lk ();

  fskm_tone_synth u_synth (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .lk      (lk)
  );

  fskm_demod u_demod (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .lk      (lk)
  );

  fskm_bus_st_t st_q;
  logic         waitreq_q;
  logic [31:0]  rdata_q;
  logic [7:0]   ctrl_q;
  logic [7:0]   ref_cnt_q;
  logic         tick_q;
  logic [7:0]   tone_q;
  logic         tone_act_q;
  logic         rx_bit_q;
  logic         pullup_q;
  fskm_per_t    smp_cnt_q;
  logic         pend_q;
  logic         pdat_q;
  logic         head_v_q;
  logic         head_d_q;
  logic         spare_v_q;
  logic         spare_d_q;
  logic         rx_orig;
  logic         push;
  logic         pop;

  // Reference tick: one enable pulse per microsecond.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_cnt_q <= 8'h00;
      tick_q    <= 1'b0;
    end else if (ref_cnt_q == REF_LAST) begin
      ref_cnt_q <= 8'h00;
      tick_q    <= 1'b1;
    end else begin
      ref_cnt_q <= ref_cnt_q + 8'h01;
      tick_q    <= 1'b0;
    end
  end

  function automatic logic [31:0] rd_mux(input logic [3:0] a);
    unique case (a)
      `FSKM_OFS_CTRL: rd_mux = {24'h000000, ctrl_q};
      `FSKM_OFS_STAT: rd_mux = {28'h0000000, spare_v_q, head_v_q,
                                tone_act_q, rx_bit_q};
      default:        rd_mux = 32'h00000000;
    endcase
  endfunction

  // Every access is answered one cycle after it is first seen.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q      <= BUS_IDLE;
      waitreq_q <= 1'b1;
      rdata_q   <= 32'h00000000;
    end else begin
      unique case (st_q)
        BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            st_q      <= BUS_ACK;
            waitreq_q <= 1'b0;
            rdata_q   <= avs_read_i ? rd_mux(avs_address_i) : 32'h0;
          end
        end
        BUS_ACK: begin
          st_q      <= BUS_IDLE;
          waitreq_q <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `FSKM_CTRL_RST;
    end else if (st_q == BUS_ACK && avs_write_i &&
                 avs_address_i == `FSKM_OFS_CTRL && avs_byteenable_i[0]) begin
      ctrl_q <= avs_writedata_i[7:0];
    end
  end

  // Receive pair is the far end's transmit pair unless looped back.
  assign rx_orig = ctrl_q[`FSKM_B_LOOP] ? ctrl_q[`FSKM_B_MODE]
                                        : ~ctrl_q[`FSKM_B_MODE];
  assign lk.tick  = tick_q;
  assign lk.tx_on = ctrl_q[`FSKM_B_TXEN];
  assign lk.inc   = tx_inc(ctrl_q[`FSKM_B_STD], ctrl_q[`FSKM_B_MODE],
                           tx_bit_i, ctrl_q[`FSKM_B_ECHO]);
  assign lk.carrier = ctrl_q[`FSKM_B_LOOP] ? lk.square
                                           : rx_carrier_i;
  assign lk.thresh = ctrl_q[`FSKM_B_STD] ? (rx_orig ? TH_UO : TH_UA)
                                         : (rx_orig ? TH_C1 : TH_C2);
  assign lk.mark_short = ctrl_q[`FSKM_B_STD];
  assign lk.half_bit   = half_of(ctrl_q[`FSKM_B_RATE], ctrl_q[`FSKM_B_STD]);
  assign lk.demod_rst  = ctrl_q[`FSKM_B_DRST];

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tone_q     <= `FSKM_MID;
      tone_act_q <= 1'b0;
    end else begin
      tone_q     <= ctrl_q[`FSKM_B_TXEN] ? lk.sample : `FSKM_MID;
      tone_act_q <= ctrl_q[`FSKM_B_TXEN];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_bit_q <= 1'b1;
      pullup_q <= 1'b1;
    end else begin
      rx_bit_q <= lk.rx_bit;
      pullup_q <= ~ctrl_q[`FSKM_B_PUD];
    end
  end

  // One sample per bit period; a full buffer stalls the sampler.
  assign push = pend_q & ~spare_v_q;
  assign pop  = head_v_q & rx_ready_i;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      smp_cnt_q <= '0;
      pend_q    <= 1'b0;
      pdat_q    <= 1'b0;
    end else if (lk.demod_rst) begin
      smp_cnt_q <= '0;
      pend_q    <= 1'b0;
    end else if (pend_q) begin
      if (push) begin
        pend_q <= 1'b0;
      end
    end else if (tick_q) begin
      if (smp_cnt_q >= {lk.half_bit[11:0], 1'b0} - 13'd1) begin
        smp_cnt_q <= '0;
        pend_q    <= 1'b1;
        pdat_q    <= lk.rx_bit;
      end else begin
        smp_cnt_q <= smp_cnt_q + 13'd1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      head_v_q  <= 1'b0;
      head_d_q  <= 1'b0;
      spare_v_q <= 1'b0;
      spare_d_q <= 1'b0;
    end else if (!head_v_q || (pop && !spare_v_q)) begin
      head_v_q <= push;
      if (push) begin
        head_d_q <= pdat_q;
      end
    end else if (pop) begin
      head_d_q  <= spare_d_q;
      spare_v_q <= push;
      if (push) begin
        spare_d_q <= pdat_q;
      end
    end else if (push) begin
      spare_v_q <= 1'b1;
      spare_d_q <= pdat_q;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = waitreq_q;
  assign tone_o            = tone_q;
  assign tone_active_o     = tone_act_q;
  assign rx_bit_o          = rx_bit_q;
  assign rx_valid_o        = head_v_q;
  assign rx_data_o         = head_d_q;
  assign pullup_en_o       = pullup_q;

  a_tick_spacing: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    tick_q |=> !tick_q [*8])
    else $error("Reference tick pulses too close together.");

  a_tone_off: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !ctrl_q[`FSKM_B_TXEN] ##1 !ctrl_q[`FSKM_B_TXEN]
      |-> tone_o == `FSKM_MID && !tone_active_o)
    else $error("Tone output active while transmit is disabled.");

  a_echo_tone: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    ctrl_q[`FSKM_B_ECHO] && !ctrl_q[`FSKM_B_STD] && !ctrl_q[`FSKM_B_MODE]
      && tx_bit_i |-> lk.inc == INC_ECHO)
    else $error("Echo suppressor tone not selected.");

  a_us_mark: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    ctrl_q[`FSKM_B_STD] && ctrl_q[`FSKM_B_MODE] && tx_bit_i
      |-> lk.inc == INC_UOM)
    else $error("Originate mark frequency wrong.");

  a_cc_space: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !ctrl_q[`FSKM_B_STD] && !tx_bit_i
      |-> lk.inc == (ctrl_q[`FSKM_B_MODE] ? INC_C1S : INC_C2S))
    else $error("International space frequency wrong.");

  a_rate_sel: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    ctrl_q[`FSKM_B_RATE] && !ctrl_q[`FSKM_B_STD] |-> lk.half_bit == 13'd2500)
    else $error("200 bps half period wrong.");

  a_loop_src: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    ctrl_q[`FSKM_B_LOOP] |-> lk.carrier == lk.square
      && rx_orig == ctrl_q[`FSKM_B_MODE])
    else $error("Loopback does not feed own tone to demodulator.");

  a_pullup: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    ##1 pullup_en_o == !$past(ctrl_q[`FSKM_B_PUD]))
    else $error("Pull-up enable does not follow disable bit.");

  a_bus_ack: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("Bus access not answered in one cycle.");

  a_buf_hold: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
    else $error("Buffered word dropped while stalled.");

  c_tone_on: cover property (
    @(posedge clock_i) disable iff (!rst_n_i) $rose(tone_active_o));
  c_echo: cover property (
    @(posedge clock_i) disable iff (!rst_n_i)
    tone_active_o && lk.inc == INC_ECHO);
  c_buf_full: cover property (
    @(posedge clock_i) disable iff (!rst_n_i) spare_v_q && pend_q);
endmodule

// File: core/fskm_defs.svh
`ifndef FSKM_DEFS_SVH
`define FSKM_DEFS_SVH
`define FSKM_CLK_HZ   250000000
`define FSKM_REF_HZ   1000000
`define FSKM_REF_DIV  (`FSKM_CLK_HZ / `FSKM_REF_HZ)
`define FSKM_ACC_ONE  64'd16777216
`define FSKM_F_US_OM  1270
`define FSKM_F_US_AM  2225
`define FSKM_F_US_AS  2025
`define FSKM_F_CC1_S  1180
`define FSKM_F_CC2_S  1850
`define FSKM_F_ECHO   2100
`define FSKM_HALF_200 ((`FSKM_REF_HZ / 200) / 2)
`define FSKM_HALF_300 ((`FSKM_REF_HZ / 300) / 2)
`define FSKM_HALF_600 ((`FSKM_REF_HZ / 600) / 2)
`define FSKM_OFS_CTRL 4'h0
`define FSKM_OFS_STAT 4'h4
`define FSKM_CTRL_RST 8'h00
`define FSKM_B_STD    0
`define FSKM_B_MODE   1
`define FSKM_B_RATE   2
`define FSKM_B_ECHO   3
`define FSKM_B_TXEN   4
`define FSKM_B_LOOP   5
`define FSKM_B_DRST   6
`define FSKM_B_PUD    7
`define FSKM_MID      8'h80
`endif

// File: core/fskm_demod.sv
module fskm_demod
  import fskm_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  fskm_link_if.dem  lk
);
  logic      car_q;
  logic      raw_q;
  logic      bit_q;
  fskm_per_t per_q;
  fskm_per_t hold_q;
  logic      rise;

  assign rise = lk.carrier & ~car_q;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      car_q <= 1'b0;
      per_q <= '0;
      raw_q <= 1'b1;
    end else begin
      car_q <= lk.carrier;
      if (lk.demod_rst) begin
        per_q <= '0;
        raw_q <= 1'b1;
      end else if (rise) begin
        per_q <= '0;
        raw_q <= lk.mark_short ? (per_q < lk.thresh)
                               : (per_q >= lk.thresh);
      end else if (lk.tick && per_q != '1) begin
        per_q <= per_q + 13'd1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_q  <= 1'b1;
      hold_q <= '0;
    end else if (lk.demod_rst) begin
      bit_q  <= 1'b1;
      hold_q <= '0;
    end else if (raw_q == bit_q) begin
      hold_q <= '0;
    end else if (lk.tick) begin
      if (hold_q > lk.half_bit) begin
        bit_q  <= raw_q;
        hold_q <= '0;
      end else begin
        hold_q <= hold_q + 13'd1;
      end
    end
  end

  assign lk.rx_bit = bit_q;

  a_bit_hold: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $changed(bit_q) && !$past(lk.demod_rst)
      |-> $past(hold_q) > $past(lk.half_bit))
    else $error("Recovered bit changed before half a bit period.");

  a_bit_follow: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $changed(bit_q) && !$past(lk.demod_rst) |-> bit_q == $past(raw_q))
    else $error("Recovered bit does not follow the detected tone.");

  a_demod_off: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    lk.demod_rst |=> bit_q && hold_q == '0 && per_q == '0)
    else $error("Demodulator active while held in reset.");

  c_bit_flip: cover property (
    @(posedge clock_i) disable iff (!rst_n_i) $fell(bit_q));
endmodule

// File: core/fskm_link_if.sv
interface fskm_link_if;
  import fskm_pkg::*;
  logic      tick;
  logic      tx_on;
  fskm_inc_t inc;
  logic [7:0] sample;
  logic      square;
  logic      carrier;
  fskm_per_t thresh;
  logic      mark_short;
  fskm_per_t half_bit;
  logic      demod_rst;
  logic      rx_bit;
  modport ctl (output tick, tx_on, inc, carrier, thresh, mark_short,
               half_bit, demod_rst, input sample, square, rx_bit);
  modport syn (input tick, tx_on, inc, output sample, square);
  modport dem (input tick, carrier, thresh, mark_short, half_bit,
               demod_rst, output rx_bit);
endinterface

// File: core/fskm_pkg.sv
package fskm_pkg;
  typedef enum {BUS_IDLE, BUS_ACK} fskm_bus_st_t;
  typedef logic [23:0] fskm_inc_t;
  typedef logic [12:0] fskm_per_t;
endpackage

// File: core/fskm_tone_synth.sv
module fskm_tone_synth
  import fskm_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  fskm_link_if.syn  lk
);
  localparam logic [6:0] QTAB [16] = '{7'd6, 7'd19, 7'd31, 7'd43,
    7'd54, 7'd65, 7'd76, 7'd85, 7'd94, 7'd102, 7'd109, 7'd115,
    7'd120, 7'd123, 7'd126, 7'd127};

  fskm_inc_t  acc_q;
  logic [7:0] smp_q;

  // Quarter-wave table folded out to a full offset-binary sine.
  function automatic logic [7:0] sine(input logic [5:0] ph);
    logic [3:0] idx;
    logic [7:0] mag;
    idx  = ph[4] ? ~ph[3:0] : ph[3:0];
    mag  = {1'b0, QTAB[idx]};
    sine = ph[5] ? `FSKM_MID - mag : `FSKM_MID + mag;
  endfunction

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q <= '0;
    end else if (!lk.tx_on) begin
      acc_q <= '0;
    end else if (lk.tick) begin
      acc_q <= acc_q + lk.inc;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      smp_q <= `FSKM_MID;
    end else begin
      smp_q <= sine(acc_q[23:18]);
    end
  end

  assign lk.sample = smp_q;
  assign lk.square = acc_q[23];
endmodule

// File: tb/fskm_remote_model.sv
module fskm_remote_model #(
  parameter int CYC_PER_US = 250
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic [11:0] freq_i,
  input  wire logic        stall_i,
  output logic             carrier_o,
  output logic             ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q;
  // Limited line carrier, 50 percent duty, new frequency applied to the half period under way.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q     <= 0;
      carrier_o <= 1'b0;
    end else if (cnt_q >= CYC_PER_US * 500000 / int'(freq_i) - 1) begin
      cnt_q     <= 0;
      carrier_o <= !carrier_o;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
  // The serial sink only takes bits while the bench lets it.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= !stall_i;
    end
  end
endmodule

// File: tb/tb_fsk_modem_core.sv
module tb_fsk_modem_core;
  timeunit 1ns;
  timeprecision 1ps;
  // Clocks per reference tick; a short tick keeps the run brief.
  localparam int US = 10;
  logic        clock_i          = 1'b0;
  logic        rst_n_i          = 1'b0;
  logic [3:0]  avs_address_i    = 4'h0;
  logic        avs_read_i       = 1'b0;
  logic        avs_write_i      = 1'b0;
  logic [31:0] avs_writedata_i  = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'h0;
  logic        tx_bit_i         = 1'b0;
  logic [11:0] freq             = 12'd2225;
  logic        stall            = 1'b1;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [7:0]  tone_o;
  logic        tone_active_o;
  logic        rx_bit_o;
  logic        rx_valid_o;
  logic        rx_data_o;
  logic        rx_ready_i;
  logic        rx_carrier_i;
  logic        pullup_en_o;
  logic [31:0] q;
  logic        bad;
  int          n_errors   = 0;
  int          n_compared = 0;
  int          n;
  int          e;
  logic [7:0]  t_ctrl [5] = '{8'h13, 8'h11, 8'h11, 8'h12, 8'h18};
  logic        t_bit  [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  int          t_freq [5] = '{1270, 2225, 2025, 1180, 2100};

  always #2 clock_i = ~clock_i;

  fskm_core #(.REF_DIV(US)) dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .tx_bit_i(tx_bit_i),
    .rx_carrier_i(rx_carrier_i), .tone_o(tone_o),
    .tone_active_o(tone_active_o), .rx_bit_o(rx_bit_o),
    .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
    .rx_ready_i(rx_ready_i), .pullup_en_o(pullup_en_o)
  );

  fskm_remote_model #(.CYC_PER_US(US)) far (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .freq_i(freq),
    .stall_i(stall), .carrier_o(rx_carrier_i), .ready_o(rx_ready_i)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic xfer(input logic wr, input logic [3:0] a,
                      input logic [31:0] d, input logic [3:0] be);
    avs_address_i    <= a;
    avs_writedata_i  <= d;
    avs_byteenable_i <= be;
    avs_write_i      <= wr;
    avs_read_i       <= !wr;
    do begin
      @(posedge clock_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    chk(avs_waitrequest_o, 1'b0);
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d}, 4'hf);
    repeat (2) @(posedge clock_i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0, 4'hf);
    chk(q, x);
  endtask

  task automatic wait_rx(input logic v, input int lo, input int hi);
    n = 0;
    while (rx_bit_o !== v && n < hi * US) begin
      @(posedge clock_i);
      n++;
    end
    chk_rng(n, lo * US, hi * US - 1);
  endtask

  // Time between two sign changes of the sine, in clock cycles.
  task automatic half_per();
    logic s;
    for (int k = 0; k < 2; k++) begin
      s = tone_o[7];
      n = 0;
      while (tone_o[7] === s && n < 200000) begin
        @(posedge clock_i);
        n++;
      end
    end
  endtask

  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (150000) @(posedge clock_i);
    n_errors++;
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    chk(tone_o, 8'h80);
    chk(tone_active_o, 1'b0);
    chk(pullup_en_o, 1'b1);
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h1);
    $display("test reset_values done");
    rd(4'h8, 32'h0);
    xfer(1'b1, 4'hc, 32'hff, 4'hf);
    xfer(1'b1, 4'h0, 32'hff, 4'he);
    rd(4'h0, 32'h0);
    wr(4'h0, 8'h80);
    chk(pullup_en_o, 1'b0);
    rd(4'h0, 32'h80);
    wr(4'h4, 8'hff);
    rd(4'h4, 32'h1);
    wr(4'h0, 8'h00);
    chk(pullup_en_o, 1'b1);
    $display("test bus_and_pullups done");
    wr(4'h0, 8'h03);
    bad = 1'b0;
    for (int k = 0; k < 2000; k++) begin
      tx_bit_i <= k[3];
      @(posedge clock_i);
      if (tone_o !== 8'h80 || tone_active_o !== 1'b0) bad = 1'b1;
    end
    chk(bad, 1'b0);
    $display("test tone_silent done");
    for (int i = 0; i < 5; i++) begin
      tx_bit_i <= t_bit[i];
      wr(4'h0, t_ctrl[i]);
      chk(tone_active_o, 1'b1);
      repeat (10) @(posedge clock_i);
      half_per();
      e = US * 500000 / t_freq[i];
      chk_rng(n, e - e/50, e + e/50);
    end
    wr(4'h0, 8'h00);
    $display("test tone_table done");
    wr(4'h0, 8'h03);
    repeat (1400 * US) @(posedge clock_i);
    chk(rx_bit_o, 1'b1);
    freq <= 12'd2025;
    wait_rx(1'b0, 800, 1500);
    $display("test demod_space done");
    wr(4'h0, 8'h43);
    wait_rx(1'b1, 0, 4);
    bad = 1'b0;
    repeat (500 * US) begin
      @(posedge clock_i);
      if (rx_bit_o !== 1'b1) bad = 1'b1;
    end
    chk(bad, 1'b0);
    $display("test demod_reset done");
    freq <= 12'd2225;
    tx_bit_i <= 1'b0;
    wr(4'h0, 8'h31);
    wait_rx(1'b0, 1450, 1700);
    $display("test loopback done");
    wr(4'h0, 8'h07);
    wait_rx(1'b1, 1600, 2700);
    $display("test rate_300 done");
    wr(4'h0, 8'h44);
    rd(4'h4, 32'hd);
    stall <= 1'b0;
    n = 0;
    repeat (20) begin
      @(posedge clock_i);
      if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) begin
        if (n == 0) chk(rx_data_o, 1'b1);
        n++;
      end
    end
    chk(n, 2);
    rd(4'h4, 32'h1);
    $display("test buffer_drain done");
    wrap_up();
  end
endmodule
